// *** rtl/serial_register_write_update.sv ***
// Serial register write port with deferred update scheduling.
// Assumes pins are asynchronous; a register map outside gives
// the update kind of each fixed-area address and stores applied words.
`timescale 1ns/10ps
module serial_register_write_update #(
    parameter int DEPTH = 8
) (
    input  wire logic                               sys_clk,
    input  wire logic                               resetn,
    input  wire logic                               serial_clock,
    input  wire logic                               serial_load,
    input  wire logic                               serial_data,
    input  wire logic                               vertical_sync,
    input  wire logic                               horizontal_sync,
    input  wire logic                               sensor_gate_line,
    input  wire logic                               sequence_change_point,
    input  wire serial_reg_pkg::update_kind_t       fixed_update_kind,
    output logic      [11:0]                        lookup_addr,
    output logic                                    apply_valid,
    output logic      [11:0]                        apply_addr,
    output logic      [27:0]                        apply_data,
    output serial_reg_pkg::update_kind_t            apply_kind,
    output logic      [serial_reg_pkg::COUNT_W-1:0] pattern_group_count,
    output logic      [serial_reg_pkg::COUNT_W-1:0] sequence_count,
    output logic      [serial_reg_pkg::DELAY_LINE_W-1:0] delay_line,
    output logic                                    write_dropped
);

    localparam int IW = $clog2(DEPTH);

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_ADDR,
        PH_DATA
    } phase_t;

    typedef struct packed {
        phase_t                                   phase;
        logic [5:0]                               bit_cnt;
        logic [11:0]                              addr;
        logic [27:0]                              shift;
        logic [11:0]                              line_cnt;
        logic                                     armed;
        logic [DEPTH-1:0]                         pend_vld;
        logic [DEPTH-1:0]                         pend_rdy;
        logic [DEPTH-1:0]                         pend_nodly;
        logic [DEPTH-1:0][11:0]                   pend_addr;
        logic [DEPTH-1:0][27:0]                   pend_data;
        serial_reg_pkg::update_kind_t [DEPTH-1:0] pend_kind;
        logic                                     apply_valid;
        logic [11:0]                              apply_addr;
        logic [27:0]                              apply_data;
        serial_reg_pkg::update_kind_t             apply_kind;
        logic [27:0]                              delay_reg;
        logic [27:0]                              counts_reg;
        logic                                     dropped;
    } state_t;

    state_t q;
    state_t d;

    logic [serial_reg_pkg::SYN_N-1:0] lvl;
    logic [serial_reg_pkg::SYN_N-1:0] rise;
    logic [serial_reg_pkg::SYN_N-1:0] fall;

    pin_sync #(
        .WIDTH (serial_reg_pkg::SYN_N)
    ) u_sync (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .pin     ({sequence_change_point, sensor_gate_line, horizontal_sync,
                   vertical_sync, serial_data, serial_load, serial_clock}),
        .level   (lvl),
        .rise    (rise),
        .fall    (fall)
    );

    serial_reg_pkg::area_t area;

    area_decode u_area (
        .addr                (q.addr),
        .pattern_group_count (q.counts_reg[serial_reg_pkg::PAT_CNT_LSB +: serial_reg_pkg::COUNT_W]),
        .sequence_count      (q.counts_reg[serial_reg_pkg::SEQ_CNT_LSB +: serial_reg_pkg::COUNT_W]),
        .area                (area)
    );

    function automatic logic [IW:0] first_set(input logic [DEPTH-1:0] v);
        logic [IW:0] r;
        r = '0;
        for (int i = DEPTH - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, IW'(i)};
            end
        end
        return r;
    endfunction

    logic                             sclk_rise;
    logic                             vs_fall;
    logic                             hs_fall;
    logic                             commit;
    logic [27:0]                      word;
    serial_reg_pkg::update_kind_t     ckind;
    logic [DEPTH-1:0]                 match;
    logic [IW:0]                      hit;
    logic [IW:0]                      free;
    logic [IW:0]                      rdy;
    logic [11:0]                      dly;

    // Levels reset low, so a pin idling high gives no false fall
    always_comb begin
        d         = q;
        sclk_rise = rise[serial_reg_pkg::SYN_SCLK];
        vs_fall   = fall[serial_reg_pkg::SYN_VS];
        hs_fall   = fall[serial_reg_pkg::SYN_HS];
        dly       = q.delay_reg[serial_reg_pkg::DELAY_LINE_LSB +: serial_reg_pkg::DELAY_LINE_W];
        word      = {lvl[serial_reg_pkg::SYN_DATA], q.shift[27:1]};
        commit    = 1'b0;
        ckind     = fixed_update_kind;
        d.apply_valid = 1'b0;

        // Mark pending entries whose update point has arrived
        if (vs_fall) begin
            d.line_cnt = '0;
            d.armed    = (dly != 12'h000);
        end else if (hs_fall) begin
            d.line_cnt = q.line_cnt + 12'h001;
        end
        for (int i = 0; i < DEPTH; i++) begin
            if (q.pend_vld[i]) begin
                unique case (q.pend_kind[i])
                    serial_reg_pkg::UPD_VSYNC: begin
                        if (vs_fall && (q.pend_nodly[i] || dly == 12'h000)) begin
                            d.pend_rdy[i] = 1'b1;
                        end
                        if (q.armed && hs_fall && !q.pend_nodly[i]
                            && 12'(q.line_cnt + 12'h001) == dly) begin
                            d.pend_rdy[i] = 1'b1;
                        end
                    end
                    serial_reg_pkg::UPD_SGLINE: begin
                        if (hs_fall && lvl[serial_reg_pkg::SYN_SG]) begin
                            d.pend_rdy[i] = 1'b1;
                        end
                    end
                    serial_reg_pkg::UPD_SCP: begin
                        if (rise[serial_reg_pkg::SYN_SCP]) begin
                            d.pend_rdy[i] = 1'b1;
                        end
                    end
                    serial_reg_pkg::UPD_IMMEDIATE: begin
                    end
                endcase
            end
        end
        if (q.armed && hs_fall && 12'(q.line_cnt + 12'h001) == dly) begin
            d.armed = 1'b0;
        end

        // Serial framing; strobe low abandons any partial word
        if (!lvl[serial_reg_pkg::SYN_LOAD]) begin
            d.phase   = PH_IDLE;
            d.bit_cnt = '0;
        end else begin
            unique case (q.phase)
                PH_IDLE: begin
                    d.phase   = PH_ADDR;
                    d.bit_cnt = '0;
                end
                PH_ADDR: begin
                    if (sclk_rise) begin
                        d.addr    = {lvl[serial_reg_pkg::SYN_DATA], q.addr[11:1]};
                        d.bit_cnt = q.bit_cnt + 6'h01;
                        if (q.bit_cnt == 6'(serial_reg_pkg::ADDR_LAST)) begin
                            d.phase   = PH_DATA;
                            d.bit_cnt = '0;
                        end
                    end
                end
                PH_DATA: begin
                    if (sclk_rise) begin
                        d.shift   = word;
                        d.bit_cnt = q.bit_cnt + 6'h01;
                        if (q.bit_cnt == 6'(serial_reg_pkg::DATA_LAST)) begin
                            commit    = 1'b1;
                            d.bit_cnt = '0;
                            d.addr    = q.addr + 12'h001;
                        end
                    end
                end
            endcase
        end

        // Update kind follows the area; fields ignore the line delay
        unique case (area)
            serial_reg_pkg::AREA_PATTERN,
            serial_reg_pkg::AREA_SEQUENCE: ckind = serial_reg_pkg::UPD_SCP;
            serial_reg_pkg::AREA_FIELD:    ckind = serial_reg_pkg::UPD_VSYNC;
            default:                       ckind = fixed_update_kind;
        endcase
        for (int i = 0; i < DEPTH; i++) begin
            match[i] = q.pend_vld[i] && q.pend_addr[i] == q.addr;
        end
        hit  = first_set(match);
        free = first_set(~q.pend_vld);

        if (commit) begin
            if (area == serial_reg_pkg::AREA_UNDEF) begin
                d.dropped = 1'b1;
            end else if (ckind == serial_reg_pkg::UPD_IMMEDIATE) begin
                d.apply_valid = 1'b1;
                d.apply_addr  = q.addr;
                d.apply_data  = word;
                d.apply_kind  = ckind;
            end else if (hit[IW] || free[IW]) begin
                // Rewrite replaces the word; a same-cycle update point still wins
                d.pend_vld[hit[IW] ? hit[IW-1:0] : free[IW-1:0]]   = 1'b1;
                d.pend_rdy[hit[IW] ? hit[IW-1:0] : free[IW-1:0]]   = hit[IW] && d.pend_rdy[hit[IW-1:0]];
                d.pend_addr[hit[IW] ? hit[IW-1:0] : free[IW-1:0]]  = q.addr;
                d.pend_data[hit[IW] ? hit[IW-1:0] : free[IW-1:0]]  = word;
                d.pend_kind[hit[IW] ? hit[IW-1:0] : free[IW-1:0]]  = ckind;
                d.pend_nodly[hit[IW] ? hit[IW-1:0] : free[IW-1:0]] = (area == serial_reg_pkg::AREA_FIELD);
            end else begin
                // No room left; the word is lost and flagged
                d.dropped = 1'b1;
            end
        end

        // One release per cycle; an immediate write takes the port first
        rdy = first_set(d.pend_vld & d.pend_rdy);
        if (!d.apply_valid && rdy[IW]) begin
            d.apply_valid          = 1'b1;
            d.apply_addr           = d.pend_addr[rdy[IW-1:0]];
            d.apply_data           = d.pend_data[rdy[IW-1:0]];
            d.apply_kind           = d.pend_kind[rdy[IW-1:0]];
            d.pend_vld[rdy[IW-1:0]] = 1'b0;
            d.pend_rdy[rdy[IW-1:0]] = 1'b0;
        end

        if (d.apply_valid && d.apply_addr == serial_reg_pkg::DELAY_LINE_ADDR) begin
            d.delay_reg = d.apply_data;
        end
        if (d.apply_valid && d.apply_addr == serial_reg_pkg::CONFIG_COUNTS_ADDR) begin
            d.counts_reg = d.apply_data;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            q            <= '0;
            q.delay_reg  <= serial_reg_pkg::DELAY_LINE_RESET;
            q.counts_reg <= serial_reg_pkg::CONFIG_COUNTS_RESET;
        end else begin
            q <= d;
        end
    end

    assign lookup_addr         = q.addr;
    assign apply_valid         = q.apply_valid;
    assign apply_addr          = q.apply_addr;
    assign apply_data          = q.apply_data;
    assign apply_kind          = q.apply_kind;
    assign pattern_group_count = q.counts_reg[serial_reg_pkg::PAT_CNT_LSB +: serial_reg_pkg::COUNT_W];
    assign sequence_count      = q.counts_reg[serial_reg_pkg::SEQ_CNT_LSB +: serial_reg_pkg::COUNT_W];
    assign delay_line          = dly;
    assign write_dropped       = q.dropped;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence addr_done_s;
        q.phase == PH_ADDR && q.bit_cnt == 6'd11 && sclk_rise && lvl[serial_reg_pkg::SYN_LOAD];
    endsequence
    sequence imm_commit_s;
        commit && area != serial_reg_pkg::AREA_UNDEF && ckind == serial_reg_pkg::UPD_IMMEDIATE;
    endsequence

    addr_to_data_a: assert property (addr_done_s |=> q.phase == PH_DATA && q.bit_cnt == 6'd0)
        else $error("address field did not hand over to data after 12 bits");
    lsb_first_a: assert property (q.phase == PH_ADDR && sclk_rise && lvl[serial_reg_pkg::SYN_LOAD]
        |=> q.addr[11] == $past(lvl[serial_reg_pkg::SYN_DATA]))
        else $error("address bit not shifted in from the top");
    abandon_frame_a: assert property (!lvl[serial_reg_pkg::SYN_LOAD] |=> q.phase == PH_IDLE && !$past(commit))
        else $error("transfer not abandoned with load low");
    imm_apply_a: assert property (imm_commit_s |=> apply_valid && apply_addr == $past(q.addr)
        && apply_data == $past(word))
        else $error("immediate write not applied on the final data bit");
    burst_incr_a: assert property (commit && lvl[serial_reg_pkg::SYN_LOAD] |=> q.addr == $past(q.addr) + 12'h001)
        else $error("burst address did not step by one");
    full_word_a: assert property (apply_valid && apply_kind == serial_reg_pkg::UPD_IMMEDIATE
        |-> $past(q.phase == PH_DATA && q.bit_cnt == 6'd27))
        else $error("immediate apply without a full data word");
    pattern_area_a: assert property (q.addr >= 12'h400 && {4'h0, q.addr} < 16'h0400
        + 16'(pattern_group_count) * 16'd48 |-> area == serial_reg_pkg::AREA_PATTERN)
        else $error("pattern group address misdecoded");
    seq_area_a: assert property ({4'h0, q.addr} >= 16'h0400 + 16'(pattern_group_count) * 16'd48
        && {4'h0, q.addr} < 16'h0400 + 16'(pattern_group_count) * 16'd48 + 16'(sequence_count) * 16'd40
        |-> area == serial_reg_pkg::AREA_SEQUENCE)
        else $error("sequence address misdecoded");
    field_area_a: assert property ({4'h0, q.addr} >= 16'h0400 + 16'(pattern_group_count) * 16'd48
        + 16'(sequence_count) * 16'd40 |-> area == serial_reg_pkg::AREA_FIELD)
        else $error("field address misdecoded");
    undef_drop_a: assert property (commit && area == serial_reg_pkg::AREA_UNDEF |=> write_dropped)
        else $error("undefined-area write not flagged");
    vsync_ready_a: assert property (vs_fall && dly == 12'h000 && q.pend_vld[0] && !commit
        && q.pend_kind[0] == serial_reg_pkg::UPD_VSYNC
        |=> q.pend_rdy[0] || (apply_valid && apply_addr == $past(q.pend_addr[0])))
        else $error("vsync entry not made ready at vsync fall");
    sg_ready_a: assert property (hs_fall && lvl[serial_reg_pkg::SYN_SG] && q.pend_vld[0] && !commit
        && q.pend_kind[0] == serial_reg_pkg::UPD_SGLINE
        |=> q.pend_rdy[0] || (apply_valid && apply_addr == $past(q.pend_addr[0])))
        else $error("gate-line entry not ready at hsync fall");
    scp_ready_a: assert property (rise[serial_reg_pkg::SYN_SCP] && q.pend_vld[0] && !commit
        && q.pend_kind[0] == serial_reg_pkg::UPD_SCP
        |=> q.pend_rdy[0] || (apply_valid && apply_addr == $past(q.pend_addr[0])))
        else $error("change-point entry not made ready at change point");
    last_write_a: assert property (commit && hit[IW] && ckind != serial_reg_pkg::UPD_IMMEDIATE
        && area != serial_reg_pkg::AREA_UNDEF |=> q.pend_data[$past(hit[IW-1:0])] == $past(word))
        else $error("rewrite did not replace the pending word");

endmodule // serial_register_write_update

// *** rtl/serial_reg_pkg.sv ***
// Constants and types for the serial register write port.
// Assumes a single system clock; all pins are sampled into it.
package serial_reg_pkg;

    localparam int ADDR_W       = 12;
    localparam int DATA_W       = 28;
    localparam int ADDR_LAST    = 11;
    localparam int DATA_LAST    = 27;

    localparam logic [11:0] DELAY_LINE_ADDR    = 12'h017;
    localparam logic [11:0] CONFIG_COUNTS_ADDR = 12'h028;
    localparam logic [11:0] FIXED_LAST         = 12'h0FF;
    localparam logic [11:0] CONFIG_BASE        = 12'h400;

    localparam int PATTERN_SPAN  = 48;
    localparam int SEQUENCE_SPAN = 40;
    localparam int FIELD_SPAN    = 16;

    localparam int COUNT_W       = 8;
    localparam int PAT_CNT_LSB   = 0;
    localparam int SEQ_CNT_LSB   = 8;
    localparam int DELAY_LINE_W  = 12;
    localparam int DELAY_LINE_LSB = 0;

    localparam logic [27:0] DELAY_LINE_RESET    = 28'h000_0000;
    localparam logic [27:0] CONFIG_COUNTS_RESET = 28'h000_0000;

    localparam int SYN_SCLK = 0;
    localparam int SYN_LOAD = 1;
    localparam int SYN_DATA = 2;
    localparam int SYN_VS   = 3;
    localparam int SYN_HS   = 4;
    localparam int SYN_SG   = 5;
    localparam int SYN_SCP  = 6;
    localparam int SYN_N    = 7;

    typedef enum logic [1:0] {
        UPD_IMMEDIATE,
        UPD_VSYNC,
        UPD_SGLINE,
        UPD_SCP
    } update_kind_t;

    typedef enum logic [2:0] {
        AREA_FIXED,
        AREA_PATTERN,
        AREA_SEQUENCE,
        AREA_FIELD,
        AREA_UNDEF
    } area_t;

endpackage

// *** rtl/pin_sync.sv ***
// Three-stage pin synchroniser with edge detection.
// Assumes inputs are asynchronous to sys_clk.
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic lvl_q;
            // A change counts only once stages two and three agree
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    s1_q  <= 1'b0;
                    s2_q  <= 1'b0;
                    s3_q  <= 1'b0;
                    lvl_q <= 1'b0;
                end else begin
                    s1_q <= pin[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        lvl_q <= s3_q;
                    end
                end
            end
            assign level[g] = lvl_q;
            assign rise[g]  = s2_q & s3_q & ~lvl_q;
            assign fall[g]  = ~s2_q & ~s3_q & lvl_q;
        end
    endgenerate

endmodule // pin_sync

// *** rtl/area_decode.sv ***
// Classifies a register address into fixed, configurable or undefined areas.
// Assumes the counts come from the live configuration register.
`timescale 1ns/10ps
module area_decode (
    input  wire logic [11:0]                          addr,
    input  wire logic [serial_reg_pkg::COUNT_W-1:0]   pattern_group_count,
    input  wire logic [serial_reg_pkg::COUNT_W-1:0]   sequence_count,
    output serial_reg_pkg::area_t                     area
);

    logic [15:0] a16;
    logic [15:0] seq_base;
    logic [15:0] field_base;

    // Bases are computed, so the three groups abut with no gap
    always_comb begin
        a16        = {4'h0, addr};
        seq_base   = 16'(serial_reg_pkg::CONFIG_BASE)
                   + 16'(pattern_group_count) * 16'(serial_reg_pkg::PATTERN_SPAN);
        field_base = seq_base
                   + 16'(sequence_count) * 16'(serial_reg_pkg::SEQUENCE_SPAN);
        if (addr <= serial_reg_pkg::FIXED_LAST) begin
            area = serial_reg_pkg::AREA_FIXED;
        end else if (addr < serial_reg_pkg::CONFIG_BASE) begin
            area = serial_reg_pkg::AREA_UNDEF;
        end else if (a16 < seq_base) begin
            area = serial_reg_pkg::AREA_PATTERN;
        end else if (a16 < field_base) begin
            area = serial_reg_pkg::AREA_SEQUENCE;
        end else begin
            area = serial_reg_pkg::AREA_FIELD;
        end
    end

endmodule // area_decode

// *** tb/serial_host.sv ***
// Host model that drives the serial write port.
// Assumes sys_clk paces it; link clock period 32 ns.
`timescale 1ns/10ps
module serial_host (
    input  wire logic sys_clk,
    output logic      serial_clock,
    output logic      serial_load,
    output logic      serial_data
);
    initial begin
        serial_clock = 1'b0;
        serial_load  = 1'b0;
        serial_data  = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic bit_out(input logic b);
        serial_data  <= b;
        serial_clock <= 1'b0;
        wt(4);
        serial_clock <= 1'b1;
        wt(4);
    endtask
    task automatic open_frame(input logic [11:0] a);
        serial_load <= 1'b1;
        wt(4);
        for (int i = 0; i < 12; i++) bit_out(a[i]);
    endtask
    task automatic word(input logic [27:0] d, input int n);
        for (int i = 0; i < n; i++) bit_out(d[i]);
    endtask
    task automatic close_frame();
        wt(4);
        // Clock stands low, released data line flips
        serial_clock <= 1'b0;
        serial_load  <= 1'b0;
        serial_data  <= ~serial_data;
        wt(6);
    endtask
endmodule // serial_host

// *** tb/tb.sv ***
// Self-checking bench for the serial write port.
// Assumes serial_host model; sys_clk 250 MHz.
`timescale 1ns/10ps
module tb;
    logic                         sys_clk, resetn, sck, sld, sdt, apv, drop;
    logic [3:0]                   pn;
    serial_reg_pkg::update_kind_t kind, apk;
    logic [11:0]                  lka, apa, dly, b;
    logic [27:0]                  apd, r;
    logic [7:0]                   pcnt, scnt;
    logic [41:0]                  q[$];
    int                           fail_count, compares;
    serial_host u_host (.sys_clk(sys_clk), .serial_clock(sck), .serial_load(sld), .serial_data(sdt));
    serial_register_write_update #(.DEPTH(2)) u_dut (
        .sys_clk(sys_clk), .resetn(resetn), .serial_clock(sck), .serial_load(sld), .serial_data(sdt),
        .vertical_sync(pn[3]), .horizontal_sync(pn[2]), .sensor_gate_line(pn[1]),
        .sequence_change_point(pn[0]), .fixed_update_kind(kind), .lookup_addr(lka),
        .apply_valid(apv), .apply_addr(apa), .apply_data(apd), .apply_kind(apk),
        .pattern_group_count(pcnt), .sequence_count(scnt), .delay_line(dly), .write_dropped(drop));
    function automatic serial_reg_pkg::update_kind_t kind_of(input logic [11:0] a);
        if (a == 12'h005) return serial_reg_pkg::UPD_VSYNC;
        if (a == 12'h030) return serial_reg_pkg::UPD_SGLINE;
        return serial_reg_pkg::UPD_IMMEDIATE;
    endfunction
    always_comb kind = kind_of(lka);
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (apv === 1'b1) q.push_back({apk, apa, apd});
    task automatic chk(input logic [41:0] s, input logic [41:0] e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic got(input logic [41:0] e);
        chk(q.size() > 0 ? q.pop_front() : 'x, e);
    endtask
    task automatic idle();
        chk(42'(q.size()), 42'd0);
    endtask
    task automatic wr(input logic [11:0] a, input logic [27:0] d);
        u_host.open_frame(a);
        u_host.word(d, 28);
        u_host.close_frame();
        u_host.wt(8);
    endtask
    // Long enough for sync delay plus release
    task automatic pulse(input int i);
        u_host.wt(4);
        pn[i] <= ~pn[i];
        u_host.wt(10);
        pn[i] <= ~pn[i];
        u_host.wt(10);
    endtask
    task automatic conclude();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        fail_count = 0;
        compares = 0;
        resetn = 1'b0;
        pn = 4'b1100;
        void'($urandom(32'hdc30_9753));
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        u_host.wt(4);
        wr(12'h028, 28'h000_0403);
        got({2'd0, 12'h028, 28'h000_0403});
        chk(42'({pcnt, scnt}), 42'h0304);
        b = 12'h060 + 12'($urandom_range(0, 127));
        r = 28'($urandom);
        u_host.open_frame(b);
        for (int i = 0; i < 3; i++) u_host.word(r + 28'(i), 28);
        u_host.word(r, 9);
        u_host.close_frame();
        u_host.wt(8);
        for (int i = 0; i < 3; i++) got({2'd0, b + 12'(i), r + 28'(i)});
        chk(42'(lka), 42'(b + 12'h003));
        idle();
        wr(12'h005, r);
        idle();
        pulse(3);
        got({2'd1, 12'h005, r});
        wr(12'h030, ~r);
        pulse(2);
        idle();
        pn[1] <= 1'b1;
        pulse(2);
        got({2'd2, 12'h030, ~r});
        pn[1] <= 1'b0;
        b = 12'h400 + 12'($urandom_range(0, 143));
        wr(b, r);
        wr(b, ~r);
        wr(12'h52f, r);
        pulse(3);
        idle();
        pulse(0);
        got({2'd3, b, ~r});
        got({2'd3, 12'h52f, r});
        wr(12'h530, r);
        wr(12'h017, 28'h000_0002);
        got({2'd0, 12'h017, 28'h000_0002});
        chk(42'(dly), 42'd2);
        wr(12'h005, ~r);
        pulse(3);
        got({2'd1, 12'h530, r});
        idle();
        pulse(2);
        idle();
        pulse(2);
        got({2'd1, 12'h005, ~r});
        wr(12'h200, r);
        chk(42'(drop), 42'd1);
        idle();
        conclude();
    end
    initial begin
        #100000;
        fail_count++;
        conclude();
    end
endmodule // tb
